/* File: rtl/hber_bridge_enable.sv */
// Half-bridge enable register bank behind a 16-bit serial frame
`timescale 1ns/1ps
module hber_bridge_enable
    import hber_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_spi_sclk,
    input wire logic i_spi_csn,
    input wire logic i_spi_mosi,
    output logic o_spi_miso,
    output logic o_spi_miso_oe,
    output logic [BRIDGES-1:0] o_high_switch_on,
    output logic [BRIDGES-1:0] o_low_switch_on,
    output logic [BRIDGES-1:0] o_cross_block,
    output logic o_frame_dropped
);
    // Low-side request of each bridge from a register pair
    function automatic logic [BRIDGES-1:0] hber_low_of(input logic [15:0] regs);
        logic [BRIDGES-1:0] res;
        res = '0;
        for (int n = 0; n < BRIDGES; n++) begin
            res[n] = regs[2*n+LOW_BIT_OFS];
        end
        return res;
    endfunction

    // High-side request of each bridge from a register pair
    function automatic logic [BRIDGES-1:0] hber_high_of(input logic [15:0] regs);
        logic [BRIDGES-1:0] res;
        res = '0;
        for (int n = 0; n < BRIDGES; n++) begin
            res[n] = regs[2*n+HIGH_BIT_OFS];
        end
        return res;
    endfunction

    logic [FRAME_BITS-1:0] link_word;
    logic link_frame_toggle;
    logic link_spoil_toggle;
    logic [FRAME_BITS-1:0] reply_reg;
    logic [2:0] sync_bits;
    logic [2:0] sync_d_reg;
    logic [FRAME_BITS-1:0] word_reg;
    hber_frame_t state_reg;
    hber_frame_t state_next;
    logic [BYTE_BITS-1:0] bridge_enable_group_one_reg;
    logic [BYTE_BITS-1:0] bridge_enable_group_two_reg;
    logic [BYTE_BITS-1:0] group_one_next;
    logic [BYTE_BITS-1:0] group_two_next;

    // Link-clock shifter
    hber_spi_link u_link (
        .i_spi_sclk(i_spi_sclk),
        .i_spi_csn(i_spi_csn),
        .i_spi_mosi(i_spi_mosi),
        .i_rst(i_rst),
        .i_reply(reply_reg),
        .o_frame_word(link_word),
        .o_frame_toggle(link_frame_toggle),
        .o_spoil_toggle(link_spoil_toggle),
        .o_miso(o_spi_miso),
        .o_miso_oe(o_spi_miso_oe)
    );

    // Chip select and event toggles into the core clock
    hber_sync #(
        .WIDTH(3),
        .RESET_VALUE(SYNC_RESET)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async({i_spi_csn, link_spoil_toggle, link_frame_toggle}),
        .o_sync(sync_bits)
    );

    // Delayed copy for edge detection
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sync_d_reg <= SYNC_RESET;
        end else begin
            sync_d_reg <= sync_bits;
        end
    end

    // Edges seen in the core domain
    logic csn_rise;
    logic csn_fall;
    logic frame_edge;
    logic spoil_edge;
    assign csn_rise = sync_bits[2] & ~sync_d_reg[2];
    assign csn_fall = ~sync_bits[2] & sync_d_reg[2];
    assign frame_edge = sync_bits[0] ^ sync_d_reg[0];
    assign spoil_edge = sync_bits[1] ^ sync_d_reg[1];

    // Word settled long before its toggle arrives here
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            word_reg <= 16'h0000;
        end else if (frame_edge) begin
            word_reg <= link_word;
        end
    end

    // Frame tracking: full word, then chip select release, no extra bit
    logic frame_full;
    logic commit;
    logic dropped;
    assign frame_full = (state_reg == FR_FULL) || frame_edge;
    assign commit = csn_rise && frame_full && !spoil_edge
        && (state_reg != FR_SPOILED);
    assign dropped = csn_rise && !commit;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            FR_IDLE: begin
                if (csn_fall) begin
                    state_next = FR_ACTIVE;
                end
            end
            FR_ACTIVE: begin
                if (csn_rise) begin
                    state_next = FR_IDLE;
                end else if (spoil_edge) begin
                    state_next = FR_SPOILED;
                end else if (frame_edge) begin
                    state_next = FR_FULL;
                end
            end
            FR_FULL: begin
                if (csn_rise) begin
                    state_next = FR_IDLE;
                end else if (spoil_edge) begin
                    state_next = FR_SPOILED;
                end
            end
            FR_SPOILED: begin
                if (csn_rise) begin
                    state_next = FR_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= FR_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Address decode of the frame being committed
    logic [BYTE_BITS-1:0] frame_addr;
    logic [BYTE_BITS-1:0] frame_data;
    logic [BYTE_BITS-1:0] cur_word_addr;
    logic [BYTE_BITS-1:0] cur_word_data;
    logic is_write;
    logic sel_one;
    logic sel_two;
    logic write_one;
    logic write_two;
    assign cur_word_addr = frame_edge ? link_word[7:0] : word_reg[7:0];
    assign cur_word_data = frame_edge ? link_word[15:8] : word_reg[15:8];
    assign frame_addr = cur_word_addr;
    assign frame_data = cur_word_data;
    assign is_write = frame_addr[ADDR_DIR_BIT];
    assign sel_one = frame_addr[ADDR_CTRL_BIT]
        && (frame_addr[ADDR_SEL_HI:ADDR_SEL_LO] == SEL_GROUP_ONE);
    assign sel_two = frame_addr[ADDR_CTRL_BIT]
        && (frame_addr[ADDR_SEL_HI:ADDR_SEL_LO] == SEL_GROUP_TWO);
    assign write_one = commit && is_write && sel_one;
    assign write_two = commit && is_write && sel_two;

    // Registers change only through a committed write
    assign group_one_next = write_one ? frame_data : bridge_enable_group_one_reg;
    assign group_two_next = write_two ? frame_data : bridge_enable_group_two_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bridge_enable_group_one_reg <= CTRL_RESET;
            bridge_enable_group_two_reg <= CTRL_RESET;
        end else begin
            bridge_enable_group_one_reg <= group_one_next;
            bridge_enable_group_two_reg <= group_two_next;
        end
    end

    // Reply for the next frame: old contents plus echoed address
    logic [BYTE_BITS-1:0] read_value;
    assign read_value = sel_one ? bridge_enable_group_one_reg :
        (sel_two ? bridge_enable_group_two_reg : 8'h00);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            reply_reg <= 16'h0000;
        end else if (commit) begin
            reply_reg <= {read_value, frame_addr[7:1], 1'b0};
        end
    end

    // Switch drive with cross-current interlock
    logic [15:0] both_groups;
    logic [BRIDGES-1:0] low_req;
    logic [BRIDGES-1:0] high_req;
    logic [BRIDGES-1:0] clash;
    assign both_groups = {bridge_enable_group_two_reg, bridge_enable_group_one_reg};
    assign low_req = hber_low_of(both_groups);
    assign high_req = hber_high_of(both_groups);
    assign clash = low_req & high_req;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_low_switch_on <= 8'h00;
            o_high_switch_on <= 8'h00;
            o_cross_block <= 8'h00;
            o_frame_dropped <= 1'b0;
        end else begin
            o_low_switch_on <= low_req & ~clash;
            o_high_switch_on <= high_req & ~clash;
            o_cross_block <= clash;
            o_frame_dropped <= dropped;
        end
    end

    // Checks on the core domain
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // Full word held and not spoiled, then chip select released
    sequence seq_close_full;
        (state_reg == FR_FULL) && !spoil_edge ##1 (csn_rise && !spoil_edge);
    endsequence

    sequence seq_spoiled_close;
        (state_reg == FR_SPOILED) ##1 csn_rise;
    endsequence

    a_reset_clears: assert property (
        $past(i_rst) |-> (bridge_enable_group_one_reg == 8'h00)
            && (bridge_enable_group_two_reg == 8'h00))
        else $error("control register not cleared by reset");

    a_outputs_off_reset: assert property (
        $past(i_rst, 2) && $past(i_rst) |-> (o_high_switch_on == 8'h00)
            && (o_low_switch_on == 8'h00))
        else $error("switches on after reset");

    a_no_self_change: assert property (
        !write_one |=> $stable(bridge_enable_group_one_reg))
        else $error("group one changed without a write");

    a_read_keeps: assert property (
        commit && !is_write |=> $stable(bridge_enable_group_one_reg)
            && $stable(bridge_enable_group_two_reg))
        else $error("read frame altered a register");

    a_write_one: assert property (
        seq_close_full ##0 (word_reg[7] && word_reg[6:0] == 7'h01)
            |=> bridge_enable_group_one_reg == $past(word_reg[15:8]))
        else $error("write to group one lost");

    a_write_two: assert property (
        commit && is_write && frame_addr[6:0] == 7'h41
            |=> bridge_enable_group_two_reg == $past(frame_data))
        else $error("write to group two lost");

    a_spoiled_ignored: assert property (
        seq_spoiled_close |=> $stable(bridge_enable_group_one_reg)
            && $stable(bridge_enable_group_two_reg) && o_frame_dropped)
        else $error("overlong frame took effect");

    a_no_cross_current: assert property (
        (o_low_switch_on & o_high_switch_on) == 8'h00)
        else $error("both switches of a bridge on");

    a_bridge_one_low: assert property (
        o_low_switch_on[0] == $past(bridge_enable_group_one_reg[0]
            && !bridge_enable_group_one_reg[1]))
        else $error("bridge one low side mapping wrong");

    a_bridge_eight_high: assert property (
        o_high_switch_on[7] == $past(bridge_enable_group_two_reg[7]
            && !bridge_enable_group_two_reg[6]))
        else $error("bridge eight high side mapping wrong");

    a_zero_means_off: assert property (
        $past(bridge_enable_group_two_reg) == 8'h00 |-> o_low_switch_on[7:4] == 4'h0
            && o_high_switch_on[7:4] == 4'h0)
        else $error("switch on with bit clear");

    a_dir_bit_write: assert property (
        $changed(bridge_enable_group_one_reg) |-> $past(commit && frame_addr[7]))
        else $error("register changed without direction bit set");
endmodule

/* File: rtl/hber_pkg.sv */
// Constants and types shared by the half-bridge enable register bank
package hber_pkg;
    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int CNT_BITS = 5;
    localparam logic [4:0] CNT_FULL = 5'h10;
    localparam logic [4:0] CNT_OVER = 5'h11;
    // Address byte fields
    localparam int ADDR_DIR_BIT = 7;
    localparam int ADDR_TOKEN_BIT = 1;
    localparam int ADDR_CTRL_BIT = 0;
    localparam int ADDR_SEL_HI = 6;
    localparam int ADDR_SEL_LO = 2;
    localparam logic [4:0] SEL_GROUP_ONE = 5'h00;
    localparam logic [4:0] SEL_GROUP_TWO = 5'h10;
    // Register contents
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int BRIDGES_PER_GROUP = 4;
    localparam int BRIDGES = 8;
    localparam int LOW_BIT_OFS = 0;
    localparam int HIGH_BIT_OFS = 1;
    // Crossing
    localparam int SYNC_STAGES = 2;
    localparam logic [2:0] SYNC_RESET = 3'h4;
    // Frame tracking in the core clock domain
    typedef enum logic [1:0] {
        FR_IDLE,
        FR_ACTIVE,
        FR_FULL,
        FR_SPOILED
    } hber_frame_t;
endpackage

/* File: rtl/hber_spi_link.sv */
// Serial shifter running on the link clock
`timescale 1ns/1ps
module hber_spi_link
    import hber_pkg::*;
(
    input wire logic i_spi_sclk,
    input wire logic i_spi_csn,
    input wire logic i_spi_mosi,
    input wire logic i_rst,
    input wire logic [FRAME_BITS-1:0] i_reply,
    output logic [FRAME_BITS-1:0] o_frame_word,
    output logic o_frame_toggle,
    output logic o_spoil_toggle,
    output logic o_miso,
    output logic o_miso_oe
);
    logic [CNT_BITS-1:0] cnt_reg;
    logic [FRAME_BITS-1:0] shift_reg;
    logic [FRAME_BITS-1:0] shift_next;
    logic [CNT_BITS-1:0] cnt_next;
    logic last_bit;
    logic over_bit;

    // Least significant bit first, address byte before data byte
    assign shift_next = {i_spi_mosi, shift_reg[FRAME_BITS-1:1]};
    assign cnt_next = (cnt_reg == CNT_OVER) ? cnt_reg : cnt_reg + 5'h01;
    assign last_bit = (cnt_next == CNT_FULL);
    assign over_bit = (cnt_next == CNT_OVER) && (cnt_reg != CNT_OVER);

    // Bit counter, cleared whenever chip select is idle
    always_ff @(posedge i_spi_sclk or posedge i_spi_csn) begin
        if (i_spi_csn) begin
            cnt_reg <= 5'h00;
            shift_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
        end
    end

    // Word is held until the next full frame
    always_ff @(posedge i_spi_sclk) begin
        if (last_bit) begin
            o_frame_word <= shift_next;
        end
    end

    // Event toggles survive chip select, cleared by core reset
    always_ff @(posedge i_spi_sclk or posedge i_rst) begin
        if (i_rst) begin
            o_frame_toggle <= 1'b0;
            o_spoil_toggle <= 1'b0;
        end else begin
            o_frame_toggle <= o_frame_toggle ^ last_bit;
            o_spoil_toggle <= o_spoil_toggle ^ over_bit;
        end
    end

    // Reply shifted on falling edges; bit 0 carries no data
    always_ff @(negedge i_spi_sclk or posedge i_spi_csn) begin
        if (i_spi_csn) begin
            o_miso <= 1'b0;
            o_miso_oe <= 1'b0;
        end else begin
            o_miso <= cnt_reg[4] ? 1'b0 : i_reply[cnt_reg[3:0]];
            o_miso_oe <= 1'b1;
        end
    end
endmodule

/* File: rtl/hber_sync.sv */
// Two-flop synchroniser for a group of single-bit levels
`timescale 1ns/1ps
module hber_sync
    import hber_pkg::*;
#(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_reg <= RESET_VALUE;
            o_sync <= RESET_VALUE;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule

/* File: sim/hber_bridge_enable_tb_top.sv */
// Self-checking bench for the half-bridge enable register bank
`timescale 1ns/1ps
module hber_bridge_enable_tb_top;
    import hber_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic sclk;
    logic csn;
    logic mosi;
    logic o_spi_miso;
    logic o_spi_miso_oe;
    logic o_frame_dropped;
    logic [BRIDGES-1:0] o_high_switch_on;
    logic [BRIDGES-1:0] o_low_switch_on;
    logic [BRIDGES-1:0] o_cross_block;
    logic [7:0] reg_one = 8'h00;
    logic [7:0] reg_two = 8'h00;
    logic [15:0] rep;
    int fails = 0;
    int compares = 0;
    int drops = 0;
    int d;

    // Core clock, 25 ns
    always #12.5 i_clk = ~i_clk;

    hber_bridge_enable i_dut (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_spi_sclk(sclk),
        .i_spi_csn(csn),
        .i_spi_mosi(mosi),
        .o_spi_miso(o_spi_miso),
        .o_spi_miso_oe(o_spi_miso_oe),
        .o_high_switch_on(o_high_switch_on),
        .o_low_switch_on(o_low_switch_on),
        .o_cross_block(o_cross_block),
        .o_frame_dropped(o_frame_dropped)
    );

    hber_spi_master i_master (
        .i_miso(o_spi_miso),
        .i_miso_oe(o_spi_miso_oe),
        .o_sclk(sclk),
        .o_csn(csn),
        .o_mosi(mosi)
    );

    // Count dropped-frame pulses
    always @(posedge i_clk) begin
        if (o_frame_dropped === 1'b1) begin
            drops <= drops + 1;
        end
    end

    // Expected idle pins and switch state from the two register copies
    function automatic logic [25:0] expect_state();
        logic [15:0] r;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] cr;
        r = {reg_two, reg_one};
        for (int n = 0; n < BRIDGES; n++) begin
            cr[n] = r[2*n] & r[2*n+1];
            lo[n] = r[2*n] & ~cr[n];
            hi[n] = r[2*n+1] & ~cr[n];
        end
        return {2'b00, cr, hi, lo};
    endfunction

    task automatic chk_val(input logic [25:0] got, input logic [25:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    // Outputs looked at just after an edge, once they have settled
    task automatic chk_state();
        @(posedge i_clk);
        #1;
        chk_val({o_spi_miso_oe, o_spi_miso, o_cross_block, o_high_switch_on, o_low_switch_on},
            expect_state());
    endtask

    // One frame; the bench copy updates only on a full mapped write
    task automatic frame(input logic [7:0] addr, input logic [7:0] data, input int nbits);
        i_master.xfer({1'b1, data, addr}, nbits, rep);
        if (nbits == FRAME_BITS && addr[7] && addr[0]) begin
            if (addr[6:2] == 5'h00) reg_one = data;
            if (addr[6:2] == 5'h10) reg_two = data;
        end
    endtask

    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (60000) @(posedge i_clk);
        fails++;
        summarize();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge i_clk);
        #1 i_rst = 1'b0;
        repeat (3) @(posedge i_clk);
        chk_state();
        frame(8'h01, 8'hA5, 16);
        frame(8'h01, 8'h00, 16);
        chk_val(26'(rep & 16'hFFFE), 26'h0000000);
        chk_state();
        for (int b = 0; b < 16; b++) begin
            frame(b < 8 ? 8'h81 : 8'hC1, 8'h01 << (b % 8), 16);
            chk_state();
        end
        frame(8'h83, 8'hFF, 16);
        chk_state();
        frame(8'hC3, 8'h3C, 16);
        chk_state();
        frame(8'hC1, 8'h96, 16);
        chk_state();
        frame(8'h41, 8'h00, 16);
        frame(8'h03, 8'h55, 16);
        chk_val(26'(rep & 16'hFFFE), {10'h000, reg_two, 8'h40});
        frame(8'h01, 8'h00, 16);
        chk_val(26'(rep & 16'hFFFE), {10'h000, reg_one, 8'h02});
        chk_state();
        frame(8'h85, 8'h00, 16);
        frame(8'h80, 8'h00, 16);
        chk_state();
        d = drops;
        chk_val(26'(d), 26'h0000000);
        frame(8'h81, 8'h00, 15);
        frame(8'hC1, 8'h00, 17);
        chk_state();
        chk_val(26'(drops - d), 26'h0000002);
        repeat (200) @(posedge i_clk);
        chk_state();
        @(posedge i_clk);
        #1 i_rst = 1'b1;
        repeat (5) @(posedge i_clk);
        #1 i_rst = 1'b0;
        reg_one = 8'h00;
        reg_two = 8'h00;
        repeat (3) @(posedge i_clk);
        chk_state();
        frame(8'h81, 8'h05, 16);
        chk_val(26'(rep & 16'hFFFE), 26'h0000000);
        chk_state();
        summarize();
    end
endmodule

/* File: sim/hber_spi_master.sv */
// Behavioural serial master standing in for the external controller
`timescale 1ns/1ps
module hber_spi_master (
    input wire logic i_miso,
    input wire logic i_miso_oe,
    output logic o_sclk,
    output logic o_csn,
    output logic o_mosi
);
    // Idle: clock still, select released
    initial begin
        o_sclk = 1'b0;
        o_csn = 1'b1;
        o_mosi = 1'b0;
    end

    // One frame of nbits, address byte then data byte, LSB first
    task automatic xfer(input logic [16:0] word, input int nbits, output logic [15:0] reply);
        reply = 16'h0000;
        #7;
        o_csn = 1'b0;
        #200;
        for (int i = 0; i < nbits; i++) begin
            o_mosi = word[i];
            #40;
            o_sclk = 1'b1;
            if (i < 16) begin
                reply[i] = i_miso_oe ? i_miso : ~reply[i];
            end
            #40;
            o_sclk = 1'b0;
        end
        #40;
        o_csn = 1'b1;
        o_mosi = ~o_mosi; // Released data line must not look valid
        #300;
    endtask
endmodule
